// [rtl/sbrxe_pkg.sv]
// Package of the receive error-flag block of the serial bus controller.
// Assumes the receive path and the software access logic share one clock.
package sbrxe_pkg;

  // Number of communications modes and width of the mode selector.
  localparam int SBRXE_MODES = 4;
  localparam int SBRXE_MODE_W = 2;

  // Byte counter width.
  localparam int SBRXE_CNT_W = 8;

  // Per-frame byte limit for each mode; plain defaults, set per system.
  localparam logic [SBRXE_CNT_W-1:0] SBRXE_LIMIT [SBRXE_MODES] = '{
    8'h10, 8'h20, 8'h40, 8'h80
  };

  // Byte counter value at the start of a frame.
  localparam logic [SBRXE_CNT_W-1:0] SBRXE_CNT_RST = 8'h00;
  localparam logic [SBRXE_CNT_W-1:0] SBRXE_CNT_ONE = 8'h01;

  // Positions of the flags in the software flag word.
  localparam int SBRXE_FLG_W = 3;
  localparam int SBRXE_FLG_PAR = 0;
  localparam int SBRXE_FLG_OVF = 1;
  localparam int SBRXE_FLG_TIM = 2;
  localparam logic [SBRXE_FLG_W-1:0] SBRXE_FLG_RST = 3'h0;

  // Receive sequencer states, one-hot.
  typedef enum logic [2:0] {
    SBRXE_IDLE = 3'b001,
    SBRXE_RECV = 3'b010,
    SBRXE_WAIT = 3'b100
  } sbrxe_state_e;

  // One-cycle events from the receive path.
  typedef struct packed {
    logic frame_start;   // Header of a frame addressed to us begins.
    logic hdr_par_err;   // Parity error in a field before the data field.
    logic byte_done;     // A data byte and its parity bit were taken.
    logic data_par_err;  // The byte of byte_done has a bad parity bit.
    logic overrun;       // The byte of byte_done hit an unread buffer.
    logic msg_last;      // The byte of byte_done completes the message.
    logic rx_end_short;  // Reception ended short of the message length.
    logic timing_err;    // Receive timing violation.
  } sbrxe_evt_s;

  // Software access to the flag word, one-cycle strobes.
  typedef struct packed {
    logic rd;                        // Flag word is being read.
    logic wr;                        // Flag word is being written.
    logic [SBRXE_FLG_W-1:0] wdata;   // Data written to the flag word.
    logic rxe_clr;                   // Clears the receive error flag.
  } sbrxe_sw_s;

  // Complete state of the block.
  typedef struct packed {
    sbrxe_state_e st;
    logic [SBRXE_CNT_W-1:0] cnt;
    logic [SBRXE_FLG_W-1:0] flags;
    logic [SBRXE_FLG_W-1:0] arm;
    logic receive_error_flag;
    logic pend_pe;
    logic nak;
  } sbrxe_state_s;

endpackage : sbrxe_pkg

// [rtl/sbrxe_core.sv]
// Receive error flags of the serial bus controller: frame byte overflow,
// data parity error and receive timing error, plus NAK and wait control.
// Assumes event strobes and software strobes come from same-clock logic.
// Functional notes
// - Byte limit reached unfinished: overflow, error, wait.
// - Overflow clears by read 1, then write 0.
// - Header parity error: wait, parity flag untouched.
// - Normal data parity error: NAK, no flag yet.
// - Retry good clears; short end unresolved sets flag.
// - Broadcast data parity error: flag and wait together.
// - Last byte at limit still bad: parity flag.
// - Parity flag clears by read 1, write 0.
// - Timing violation: timing flag, error, wait.
`timescale 1ns/1ps
module sbrxe_core
  import sbrxe_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic [SBRXE_MODE_W-1:0] MODE,
  input wire logic BCAST,
  input wire sbrxe_evt_s EVT,
  input wire sbrxe_sw_s SW,
  output logic OVF_FLAG,
  output logic PAR_FLAG,
  output logic TIM_FLAG,
  output logic RX_ERR_FLAG,
  output logic NAK,
  output logic WAIT_ST
);

  // Registered and next state.
  sbrxe_state_s s_q;
  sbrxe_state_s s_d;
  // Byte limit of the active mode.
  logic [SBRXE_CNT_W-1:0] limit;
  // Byte count including the byte now being taken.
  logic [SBRXE_CNT_W-1:0] cnt_n;

  assign limit = SBRXE_LIMIT[MODE];
  assign cnt_n = s_q.cnt + SBRXE_CNT_ONE;

  // Next-state logic; software clears come first so that sets win.
  always_comb begin
    s_d = s_q;
    s_d.nak = 1'b0;
    // A read arms every flag that reads as one.
    if (SW.rd) begin
      s_d.arm = s_q.flags;
    end
    // A write of zero clears only an armed flag; the write disarms all.
    if (SW.wr) begin
      s_d.flags = s_q.flags & ~(s_q.arm & ~SW.wdata);
      s_d.arm = SBRXE_FLG_RST;
    end
    // The receive error flag has its own clear strobe.
    if (SW.rxe_clr) begin
      s_d.receive_error_flag = 1'b0;
    end
    case (s_q.st)
      SBRXE_IDLE: begin
        // Wait for a frame addressed to us.
        if (EVT.frame_start) begin
          s_d.st = SBRXE_RECV;
          s_d.cnt = SBRXE_CNT_RST;
          s_d.pend_pe = 1'b0;
        end
      end
      SBRXE_RECV: begin
        if (EVT.timing_err) begin
          // Timing violation aborts the frame.
          s_d.flags[SBRXE_FLG_TIM] = 1'b1;
          s_d.receive_error_flag = 1'b1;
          s_d.st = SBRXE_WAIT;
        end else if (EVT.hdr_par_err) begin
          // Header parity error leaves the parity flag alone.
          s_d.st = SBRXE_WAIT;
        end else if (EVT.byte_done) begin
          s_d.cnt = cnt_n;
          if (BCAST && (EVT.data_par_err || EVT.overrun)) begin
            // Broadcast has no retries: flag and leave at once.
            s_d.flags[SBRXE_FLG_PAR] =
              EVT.data_par_err | s_d.flags[SBRXE_FLG_PAR];
            // A bad byte at the limit also leaves the frame unfinished.
            if (cnt_n == limit) begin
              s_d.flags[SBRXE_FLG_OVF] = 1'b1;
            end
            s_d.receive_error_flag = 1'b1;
            s_d.st = SBRXE_WAIT;
          end else if (EVT.data_par_err || EVT.overrun) begin
            // Bad byte: refuse it and let the sender retry.
            s_d.nak = 1'b1;
            s_d.pend_pe = EVT.data_par_err;
            if (cnt_n == limit) begin
              s_d.flags[SBRXE_FLG_OVF] = 1'b1;
              s_d.flags[SBRXE_FLG_PAR] =
                EVT.data_par_err | s_d.flags[SBRXE_FLG_PAR];
              s_d.receive_error_flag = 1'b1;
              s_d.st = SBRXE_WAIT;
            end
          end else begin
            // Good byte resolves any earlier parity error.
            s_d.pend_pe = 1'b0;
            if (EVT.msg_last) begin
              s_d.st = SBRXE_IDLE;
            end else if (cnt_n == limit) begin
              s_d.flags[SBRXE_FLG_OVF] = 1'b1;
              s_d.receive_error_flag = 1'b1;
              s_d.st = SBRXE_WAIT;
            end
          end
        end else if (EVT.rx_end_short) begin
          // Early end with a parity error still open.
          if (s_q.pend_pe) begin
            s_d.flags[SBRXE_FLG_PAR] = 1'b1;
            s_d.receive_error_flag = 1'b1;
          end
          s_d.st = SBRXE_IDLE;
        end
      end
      SBRXE_WAIT: begin
        // The wait state ends when the next frame begins.
        if (EVT.frame_start) begin
          s_d.st = SBRXE_RECV;
          s_d.cnt = SBRXE_CNT_RST;
          s_d.pend_pe = 1'b0;
        end
      end
      default: begin
        s_d.st = SBRXE_IDLE;
      end
    endcase
  end

  // State register; all flags start cleared.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s_q <= '{st: SBRXE_IDLE, cnt: SBRXE_CNT_RST, flags: SBRXE_FLG_RST,
               arm: SBRXE_FLG_RST, receive_error_flag: 1'b0, pend_pe: 1'b0,
               nak: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register.
  assign OVF_FLAG = s_q.flags[SBRXE_FLG_OVF];
  assign PAR_FLAG = s_q.flags[SBRXE_FLG_PAR];
  assign TIM_FLAG = s_q.flags[SBRXE_FLG_TIM];
  assign RX_ERR_FLAG = s_q.receive_error_flag;
  assign NAK = s_q.nak;
  // One-hot state: the mask leaves the wait bit of the register alone.
  assign WAIT_ST = |(s_q.st & SBRXE_WAIT);

  // Byte limit reached on a good non-final byte raises overflow and wait.
  property p_ovf_set;
    @(posedge CLK) disable iff (RST)
    (s_q.st == SBRXE_RECV && !EVT.timing_err && !EVT.hdr_par_err &&
     EVT.byte_done && !EVT.data_par_err && !EVT.overrun &&
     !EVT.msg_last && cnt_n == limit)
    |=> OVF_FLAG && RX_ERR_FLAG && WAIT_ST;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow not set");

  // Without an armed read, a write cannot clear the overflow flag.
  property p_ovf_hold;
    @(posedge CLK) disable iff (RST)
    (OVF_FLAG && !s_q.arm[SBRXE_FLG_OVF]) |=> OVF_FLAG;
  endproperty
  a_ovf_hold: assert property (p_ovf_hold) else $error("overflow lost");

  // Read of one followed by a write of zero clears the overflow flag.
  property p_ovf_clr;
    @(posedge CLK) disable iff (RST)
    (OVF_FLAG && SW.rd && !SW.wr) ##1
    (SW.wr && !SW.wdata[SBRXE_FLG_OVF] && !SW.rd && !EVT.byte_done)
    |=> !OVF_FLAG;
  endproperty
  a_ovf_clr: assert property (p_ovf_clr) else $error("overflow stuck");

  // Header parity error sends the block to wait without a parity flag.
  property p_hdr_par;
    @(posedge CLK) disable iff (RST)
    (s_q.st == SBRXE_RECV && EVT.hdr_par_err && !EVT.timing_err && !PAR_FLAG)
    |=> WAIT_ST && !PAR_FLAG;
  endproperty
  a_hdr_par: assert property (p_hdr_par) else $error("header parity");

  // Normal-mode bad byte below the limit gives NAK and no parity flag.
  property p_nak;
    @(posedge CLK) disable iff (RST)
    (s_q.st == SBRXE_RECV && !EVT.timing_err && !EVT.hdr_par_err &&
     EVT.byte_done && EVT.data_par_err && !BCAST && cnt_n != limit &&
     !PAR_FLAG)
    |=> NAK && !PAR_FLAG ##1 (!NAK || $past(EVT.byte_done));
  endproperty
  a_nak: assert property (p_nak) else $error("NAK missing");

  // Broadcast data parity error sets the flag and enters wait together.
  property p_bcast;
    @(posedge CLK) disable iff (RST)
    (s_q.st == SBRXE_RECV && !EVT.timing_err && !EVT.hdr_par_err &&
     EVT.byte_done && EVT.data_par_err && BCAST)
    |=> PAR_FLAG && WAIT_ST && !NAK;
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast parity");

  // Bad last byte at the limit sets the parity flag.
  property p_par_lim;
    @(posedge CLK) disable iff (RST)
    (s_q.st == SBRXE_RECV && !EVT.timing_err && !EVT.hdr_par_err &&
     EVT.byte_done && EVT.data_par_err && cnt_n == limit)
    |=> PAR_FLAG && OVF_FLAG;
  endproperty
  a_par_lim: assert property (p_par_lim) else $error("parity at limit");

  // Timing violation sets timing and error flags and enters wait.
  property p_tim;
    @(posedge CLK) disable iff (RST)
    (s_q.st == SBRXE_RECV && EVT.timing_err)
    |=> TIM_FLAG && RX_ERR_FLAG && WAIT_ST;
  endproperty
  a_tim: assert property (p_tim) else $error("timing error lost");

  // Without an armed read, a write cannot clear the parity flag.
  property p_par_hold;
    @(posedge CLK) disable iff (RST)
    (PAR_FLAG && !s_q.arm[SBRXE_FLG_PAR]) |=> PAR_FLAG;
  endproperty
  a_par_hold: assert property (p_par_hold) else $error("parity lost");

  // Early end with an open parity error raises parity and error flags.
  property p_short;
    @(posedge CLK) disable iff (RST)
    (s_q.st == SBRXE_RECV && !EVT.timing_err && !EVT.hdr_par_err &&
     !EVT.byte_done && EVT.rx_end_short && s_q.pend_pe)
    |=> PAR_FLAG && RX_ERR_FLAG && !WAIT_ST;
  endproperty
  a_short: assert property (p_short) else $error("short end parity");

endmodule : sbrxe_core

// [dv/sbrxe_peer.sv]
// Remote sending unit: sends data bytes, retransmits on NAK.
// Assumes it shares the clock of the error-flag block.
`timescale 1ns/1ps
module sbrxe_peer
  import sbrxe_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire logic [7:0] len,
  input wire logic [7:0] bad,
  input wire logic [SBRXE_MODE_W-1:0] mode,
  input wire logic nak,
  output sbrxe_evt_s evt,
  output logic busy
);
  logic [1:0] ph_q; // Phase: send, idle, look at the answer.
  logic [7:0] idx_q; // Byte of the message being sent.
  logic [7:0] bad_q; // Bad copies still to send.
  logic [7:0] sent_q; // Copies sent in this frame.
  // One byte every three cycles, so the answer is seen before the next.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evt <= '0;
      busy <= 1'b0;
      ph_q <= 2'h0;
      {idx_q, bad_q, sent_q} <= '0;
    end else if (go) begin
      busy <= 1'b1;
      ph_q <= 2'h0;
      {idx_q, sent_q} <= '0;
      bad_q <= bad;
    end else if (busy) begin
      ph_q <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
      if (ph_q == 2'h0) begin
        evt <= '{byte_done: 1'b1, data_par_err: (bad_q != 8'h00),
                 msg_last: (bad_q == 8'h00) && (idx_q == len - 8'h01),
                 default: 1'b0};
        sent_q <= sent_q + 8'h01;
      end else begin
        evt <= '0;
      end
      if (ph_q == 2'h2) begin
        // A refused byte is sent again, up to the frame limit.
        if (nak) bad_q <= bad_q - 8'h01;
        else idx_q <= idx_q + 8'h01;
        if (sent_q == SBRXE_LIMIT[mode] || (!nak && idx_q == len - 8'h01))
          busy <= 1'b0;
      end
    end
  end
endmodule : sbrxe_peer

// [dv/tb_sbrxe_core.sv]
// Self-checking bench of the receive error-flag block.
// Assumes the peer model drives the data bytes, the bench the rest.
`timescale 1ns/1ps
module tb_sbrxe_core;
  import sbrxe_pkg::*;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic [SBRXE_MODE_W-1:0] mode = '0;
  logic bcast = 1'b0;
  logic go = 1'b0;
  logic [7:0] len = 8'h01;
  logic [7:0] bad = 8'h00;
  sbrxe_evt_s te = '0; // Events made by the bench itself.
  sbrxe_evt_s pe; // Events made by the peer.
  sbrxe_sw_s sw = '0;
  logic ovf, par, tim, receive_error_flag, nak, wst, busy;
  int err_count = 0;
  int tests_run = 0;
  int nak_n = 0;
  always #25 CLK = ~CLK;
  always @(posedge CLK) if (nak === 1'b1) nak_n++;
  sbrxe_core i_dut (.CLK(CLK), .RST(RST), .MODE(mode), .BCAST(bcast),
    .EVT(te | pe), .SW(sw), .OVF_FLAG(ovf), .PAR_FLAG(par),
    .TIM_FLAG(tim), .RX_ERR_FLAG(receive_error_flag), .NAK(nak), .WAIT_ST(wst));
  sbrxe_peer i_peer (.clk(CLK), .rst(RST), .go(go), .len(len), .bad(bad),
    .mode(mode), .nak(nak), .evt(pe), .busy(busy));
  // Counts a comparison and reports a mismatch.
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : tick
  // One-cycle event pulse; bit 7 is frame_start, bit 0 timing_err.
  task automatic pulse(input logic [7:0] e);
    @(posedge CLK);
    te <= sbrxe_evt_s'(e);
    @(posedge CLK);
    te <= '0;
    tick(1);
  endtask : pulse
  // Optional read, then a write of zeros and a receive error clear.
  task automatic clr(input logic rd);
    @(posedge CLK);
    sw.rd <= rd;
    @(posedge CLK);
    sw <= '{rd: 1'b0, wr: 1'b1, wdata: 3'h0, rxe_clr: 1'b1};
    @(posedge CLK);
    sw <= '0;
    tick(1);
  endtask : clr
  // A whole frame from the peer; nk returns the NAK count seen.
  task automatic frame(input logic [1:0] m, input logic [7:0] l,
                       input logic [7:0] b, output int nk);
    int n0;
    n0 = nak_n;
    pulse(8'h80);
    @(posedge CLK);
    {mode, len, bad, go} <= {m, l, b, 1'b1};
    @(posedge CLK);
    go <= 1'b0;
    for (int i = 0; i < 600; i++) begin
      @(posedge CLK);
      if (!busy) break;
    end
    chk(busy, 1'b0);
    tick(2);
    nk = nak_n - n0;
  endtask : frame
  task automatic report_and_stop();
    if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  // Retries, short end, limits, header and broadcast errors, timing.
  task automatic run_all();
    int nk;
    int n0;
    chk({ovf, par, tim, receive_error_flag}, 8'h00);
    frame(2'h0, 8'h03, 8'h02, nk);
    chk(nk[7:0], 8'h02);
    chk({ovf, par, wst}, 8'h00);
    pulse(8'h80);
    pulse(8'h30);
    pulse(8'h02);
    chk({par, receive_error_flag}, 8'h03);
    clr(1'b0);
    chk(par, 1'b1);
    clr(1'b1);
    chk({par, receive_error_flag}, 8'h00);
    // Overrun is refused with a NAK but never raises the parity flag.
    pulse(8'h80);
    n0 = nak_n;
    pulse(8'h28);
    pulse(8'h02);
    chk(8'(nak_n - n0), 8'h01);
    chk({par, receive_error_flag, wst}, 8'h00);
    frame(2'h0, 8'h20, 8'h20, nk);
    chk({ovf, par, wst, receive_error_flag}, 8'h0F);
    clr(1'b0);
    chk(ovf, 1'b1);
    clr(1'b1);
    chk({ovf, par}, 8'h00);
    for (int m = 0; m < SBRXE_MODES; m++) begin
      frame(2'(m), SBRXE_LIMIT[m], 8'h00, nk);
      chk({ovf, wst}, 8'h00);
      frame(2'(m), SBRXE_LIMIT[m] + 8'h01, 8'h00, nk);
      chk({ovf, par, wst, receive_error_flag}, 8'h0B);
      clr(1'b1);
    end
    pulse(8'h80);
    pulse(8'h40);
    chk({par, wst}, 8'h01);
    @(posedge CLK);
    bcast <= 1'b1;
    frame(2'h0, 8'h02, 8'h01, nk);
    chk(nk[7:0], 8'h00);
    chk({par, wst}, 8'h03);
    @(posedge CLK);
    bcast <= 1'b0;
    clr(1'b1);
    pulse(8'h80);
    pulse(8'h01);
    chk({tim, receive_error_flag, wst}, 8'h07);
    clr(1'b1);
    chk(tim, 1'b0);
  endtask : run_all
  initial begin
    repeat (6) @(posedge CLK);
    RST <= 1'b0;
    tick(1);
    run_all();
    report_and_stop();
  end
  // Cuts a hang short well after the expected few thousand cycles.
  initial begin
    #(50 * 20000);
    err_count++;
    report_and_stop();
  end
endmodule : tb_sbrxe_core
